// file: logic/cpu_core_pkg.sv
package cpu_core_pkg;

    // Word offsets of the software view (byte addresses, 32-bit slots)
    localparam logic [7:0]  OFF_PROGRAM_COUNTER = 8'h00;
    localparam logic [7:0]  OFF_ACCUMULATOR     = 8'h04;
    localparam logic [7:0]  OFF_TEMPORARY_ACC   = 8'h08;
    localparam logic [7:0]  OFF_INDEX_REGISTER  = 8'h0C;
    localparam logic [7:0]  OFF_EXTRA_POINTER   = 8'h10;
    localparam logic [7:0]  OFF_STACK_POINTER   = 8'h14;
    localparam logic [7:0]  OFF_PROGRAM_STATUS  = 8'h18;

    localparam logic [15:0] RST_WORD            = 16'h0000;
    localparam logic [31:0] RST_BUS_WORD        = 32'h0000_0000;

    // Program status field positions
    localparam int BANK_PTR_MSB = 15;
    localparam int BANK_PTR_LSB = 11;
    localparam int DIR_PTR_MSB  = 10;
    localparam int DIR_PTR_LSB  = 8;
    localparam int H_BIT  = 7;
    localparam int I_BIT  = 6;
    localparam int IL_MSB = 5;
    localparam int IL_LSB = 4;
    localparam int N_BIT  = 3;
    localparam int Z_BIT  = 2;
    localparam int V_BIT  = 1;
    localparam int C_BIT  = 0;

    localparam logic [15:0] DIRECT_WINDOW_BASE = 16'h0080;
    localparam logic [15:0] GR_BASE_DEFAULT    = 16'h0100;
    localparam int          GR_BANKS           = 32;
    localparam int          GR_PER_BANK        = 8;

    typedef enum logic [2:0] {
        SEL_PROGRAM_COUNTER = 3'h0,
        SEL_ACCUMULATOR     = 3'h1,
        SEL_TEMPORARY_ACC   = 3'h2,
        SEL_INDEX_REGISTER  = 3'h3,
        SEL_EXTRA_POINTER   = 3'h4,
        SEL_STACK_POINTER   = 3'h5,
        SEL_PROGRAM_STATUS  = 3'h6
    } reg_sel_t;

    typedef struct packed {
        logic [15:0] program_counter;
        logic [15:0] accumulator;
        logic [15:0] temporary_accumulator;
        logic [15:0] index_register;
        logic [15:0] extra_pointer;
        logic [15:0] stack_pointer;
        logic [15:0] program_status;
    } core_regs_t;

    typedef struct packed {
        logic        en;
        reg_sel_t    sel;
        logic [15:0] data;
    } reg_write_t;

    typedef struct packed {
        logic go;
        logic sub;
        logic wide;
        logic shift;
        logic left;
    } alu_req_t;

endpackage

// file: logic/cpu_status_and_register_banks.sv
`timescale 1ns/10ps
module cpu_status_and_register_banks
    import cpu_core_pkg::*;
#(
    parameter logic [15:0] GR_BASE = GR_BASE_DEFAULT
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Wishbone classic slave
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output logic      [31:0] wb_dat_r,
    output logic             wb_ack,
    // Instruction decoder side
    input  wire reg_write_t  core_wr,
    input  wire logic        pc_inc,
    input  wire alu_req_t    alu_req,
    input  wire logic        dir_go,
    input  wire logic [7:0]  dir_addr,
    input  wire logic [7:0]  opcode,
    input  wire logic        gr_we,
    input  wire logic [7:0]  gr_wdata,
    input  wire logic        irq_req,
    input  wire logic [1:0]  irq_level,
    output core_regs_t       regs,
    output logic      [15:0] dir_mapped,
    output logic             dir_valid,
    output logic      [15:0] gr_addr,
    output logic      [7:0]  gr_rdata,
    output logic             irq_accept
);

    logic [7:0]  gr_mem [0:GR_BANKS*GR_PER_BANK-1];
    logic        bus_req;
    logic        bus_wr;
    logic [15:0] bus_data;
    logic [31:0] next_dat_r;
    logic [15:0] next_prog_cnt;
    logic [15:0] next_acc;
    logic [15:0] next_tmp;
    logic [15:0] next_index;
    logic [15:0] next_extra;
    logic [15:0] next_stack;
    logic [15:0] next_status;
    logic [16:0] sum_wide;
    logic [8:0]  sum_byte;
    logic [4:0]  sum_nib;
    logic [15:0] alu_res;
    logic        alu_msb;
    logic        a_msb;
    logic        b_msb;
    logic        alu_carry;
    logic        alu_ovf;
    logic [7:0]  shift_res;
    logic        shift_out;
    logic [4:0]  bank_ptr;
    logic [2:0]  dir_ptr;
    logic [7:0]  gr_index;

    assign bus_req  = wb_cyc & wb_stb;
    // Writes commit on the edge that sees ack high, matching the master's sampling
    assign bus_wr   = bus_req & wb_we & wb_ack;
    assign bus_data = wb_dat_w[15:0];
    assign bank_ptr = regs.program_status[BANK_PTR_MSB:BANK_PTR_LSB];
    assign dir_ptr  = regs.program_status[DIR_PTR_MSB:DIR_PTR_LSB];
    // Bank and register number index the local copy directly, no adder needed
    assign gr_index = {bank_ptr, opcode[2:0]};

    function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                            input logic [15:0] new_val,
                                            input logic [1:0]  lanes);
        merge16 = {lanes[1] ? new_val[15:8] : old_val[15:8],
                   lanes[0] ? new_val[7:0]  : old_val[7:0]};
    endfunction

    function automatic logic hit(input logic [7:0] offset);
        hit = bus_wr && (wb_adr == offset);
    endfunction

    function automatic logic core_hit(input reg_sel_t which);
        core_hit = core_wr.en && (core_wr.sel == which);
    endfunction

    // Arithmetic on accumulator and temporary accumulator
    always_comb begin
        if (alu_req.sub) begin
            sum_wide = {1'b0, regs.accumulator} - {1'b0, regs.temporary_accumulator};
            sum_byte = {1'b0, regs.accumulator[7:0]} - {1'b0, regs.temporary_accumulator[7:0]};
            sum_nib  = {1'b0, regs.accumulator[3:0]} - {1'b0, regs.temporary_accumulator[3:0]};
        end else begin
            sum_wide = {1'b0, regs.accumulator} + {1'b0, regs.temporary_accumulator};
            sum_byte = {1'b0, regs.accumulator[7:0]} + {1'b0, regs.temporary_accumulator[7:0]};
            sum_nib  = {1'b0, regs.accumulator[3:0]} + {1'b0, regs.temporary_accumulator[3:0]};
        end
        if (alu_req.wide) begin
            alu_res   = sum_wide[15:0];
            alu_carry = sum_wide[16];
            alu_msb   = sum_wide[15];
            a_msb     = regs.accumulator[15];
            b_msb     = regs.temporary_accumulator[15];
        end else begin
            alu_res   = {regs.accumulator[15:8], sum_byte[7:0]};
            alu_carry = sum_byte[8];
            alu_msb   = sum_byte[7];
            a_msb     = regs.accumulator[7];
            b_msb     = regs.temporary_accumulator[7];
        end
        // Subtraction overflows when operand signs differ, addition when they agree
        alu_ovf = (alu_req.sub ? (a_msb ^ b_msb) : ~(a_msb ^ b_msb)) & (alu_msb ^ a_msb);
    end

    // Shifts act on the low byte only
    always_comb begin
        if (alu_req.left) begin
            shift_res = {regs.accumulator[6:0], 1'b0};
            shift_out = regs.accumulator[7];
        end else begin
            shift_res = {1'b0, regs.accumulator[7:1]};
            shift_out = regs.accumulator[0];
        end
    end

    // Decoder writes win over the bus; the ALU wins over both on its targets
    always_comb begin
        next_prog_cnt = regs.program_counter;
        if (hit(OFF_PROGRAM_COUNTER)) begin
            next_prog_cnt = merge16(regs.program_counter, bus_data, wb_sel[1:0]);
        end
        // Wraps from the top of memory back to zero
        if (pc_inc) begin
            next_prog_cnt = regs.program_counter + 16'h0001;
        end
        if (core_hit(SEL_PROGRAM_COUNTER)) begin
            next_prog_cnt = core_wr.data;
        end
    end

    always_comb begin
        next_acc = regs.accumulator;
        if (hit(OFF_ACCUMULATOR)) begin
            next_acc = merge16(regs.accumulator, bus_data, wb_sel[1:0]);
        end
        if (core_hit(SEL_ACCUMULATOR)) begin
            next_acc = core_wr.data;
        end
        if (alu_req.go) begin
            next_acc = alu_res;
        end else if (alu_req.shift) begin
            next_acc = {regs.accumulator[15:8], shift_res};
        end
    end

    always_comb begin
        next_tmp = regs.temporary_accumulator;
        next_index = regs.index_register;
        next_extra = regs.extra_pointer;
        next_stack = regs.stack_pointer;
        if (hit(OFF_TEMPORARY_ACC)) begin
            next_tmp = merge16(regs.temporary_accumulator, bus_data, wb_sel[1:0]);
        end
        if (hit(OFF_INDEX_REGISTER)) begin
            next_index = merge16(regs.index_register, bus_data, wb_sel[1:0]);
        end
        if (hit(OFF_EXTRA_POINTER)) begin
            next_extra = merge16(regs.extra_pointer, bus_data, wb_sel[1:0]);
        end
        if (hit(OFF_STACK_POINTER)) begin
            next_stack = merge16(regs.stack_pointer, bus_data, wb_sel[1:0]);
        end
        if (core_hit(SEL_TEMPORARY_ACC)) begin
            next_tmp = core_wr.data;
        end
        if (core_hit(SEL_INDEX_REGISTER)) begin
            next_index = core_wr.data;
        end
        if (core_hit(SEL_EXTRA_POINTER)) begin
            next_extra = core_wr.data;
        end
        if (core_hit(SEL_STACK_POINTER)) begin
            next_stack = core_wr.data;
        end
    end

    always_comb begin
        next_status = regs.program_status;
        if (hit(OFF_PROGRAM_STATUS)) begin
            next_status = merge16(regs.program_status, bus_data, wb_sel[1:0]);
        end
        if (core_hit(SEL_PROGRAM_STATUS)) begin
            next_status = core_wr.data;
        end
        // Flag updates override a same-cycle write of the status word
        if (alu_req.go) begin
            next_status[H_BIT] = sum_nib[4];
            next_status[N_BIT] = alu_msb;
            next_status[Z_BIT] = alu_req.wide ? (alu_res == 16'h0000)
                                              : (alu_res[7:0] == 8'h00);
            next_status[V_BIT] = alu_ovf;
            next_status[C_BIT] = alu_carry;
        end else if (alu_req.shift) begin
            // Half-carry and overflow keep their values across a shift
            next_status[C_BIT] = shift_out;
            next_status[N_BIT] = shift_res[7];
            next_status[Z_BIT] = (shift_res == 8'h00);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            regs.program_counter <= RST_WORD;
        end else begin
            regs.program_counter <= next_prog_cnt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            regs.accumulator           <= RST_WORD;
            regs.temporary_accumulator <= RST_WORD;
        end else begin
            regs.accumulator           <= next_acc;
            regs.temporary_accumulator <= next_tmp;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            regs.index_register <= RST_WORD;
            regs.extra_pointer  <= RST_WORD;
            regs.stack_pointer  <= RST_WORD;
        end else begin
            regs.index_register <= next_index;
            regs.extra_pointer  <= next_extra;
            regs.stack_pointer  <= next_stack;
        end
    end

    // Reset clears the interrupt enable and the direct bank pointer with the rest
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            regs.program_status <= RST_WORD;
        end else begin
            regs.program_status <= next_status;
        end
    end

    // Only a request level below the mask level is taken, so mask level 0 blocks everything
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_accept <= 1'b0;
        end else begin
            irq_accept <= irq_req && regs.program_status[I_BIT]
                          && (irq_level < regs.program_status[IL_MSB:IL_LSB]);
        end
    end

    // Direct address remap, one cycle of latency
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dir_mapped <= RST_WORD;
            dir_valid  <= 1'b0;
        end else begin
            dir_valid <= dir_go;
            if (dir_go) begin
                if (dir_addr[7]) begin
                    dir_mapped <= DIRECT_WINDOW_BASE + {6'h00, dir_ptr, 7'h00}
                                  + {9'h000, dir_addr[6:0]};
                end else begin
                    dir_mapped <= {8'h00, dir_addr};
                end
            end
        end
    end

    // General register banks held locally; no reset, as in data memory
    always_ff @(posedge ref_clk) begin
        if (gr_we) begin
            gr_mem[gr_index] <= gr_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gr_rdata <= 8'h00;
            gr_addr  <= RST_WORD;
        end else begin
            gr_rdata <= gr_mem[gr_index];
            // Base is a parameter: where the bank area starts may differ per variant
            gr_addr  <= GR_BASE + {8'h00, bank_ptr, 3'h0} + {13'h0000, opcode[2:0]};
        end
    end

    // Bus read mux; unmapped offsets read as zero and ignore writes
    always_comb begin
        next_dat_r = RST_BUS_WORD;
        case (wb_adr)
            OFF_PROGRAM_COUNTER: next_dat_r = {16'h0000, regs.program_counter};
            OFF_ACCUMULATOR:     next_dat_r = {16'h0000, regs.accumulator};
            OFF_TEMPORARY_ACC:   next_dat_r = {16'h0000, regs.temporary_accumulator};
            OFF_INDEX_REGISTER:  next_dat_r = {16'h0000, regs.index_register};
            OFF_EXTRA_POINTER:   next_dat_r = {16'h0000, regs.extra_pointer};
            OFF_STACK_POINTER:   next_dat_r = {16'h0000, regs.stack_pointer};
            OFF_PROGRAM_STATUS:  next_dat_r = {16'h0000, regs.program_status};
            default:             next_dat_r = RST_BUS_WORD;
        endcase
    end

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wb_ack   <= 1'b0;
            wb_dat_r <= RST_BUS_WORD;
        end else begin
            wb_ack <= bus_req & ~wb_ack;
            if (bus_req & ~wb_ack) begin
                wb_dat_r <= next_dat_r;
            end
        end
    end

endmodule

// file: verif/core_asserts.sv
`timescale 1ns/10ps
module core_asserts
    import cpu_core_pkg::*;
#(
    parameter logic [15:0] GR_BASE = GR_BASE_DEFAULT
) (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        wb_ack,
    input wire reg_write_t  core_wr,
    input wire logic        pc_inc,
    input wire alu_req_t    alu_req,
    input wire logic        dir_go,
    input wire logic [7:0]  dir_addr,
    input wire logic [7:0]  opcode,
    input wire logic        irq_req,
    input wire logic [1:0]  irq_level,
    input wire core_regs_t  regs,
    input wire logic [15:0] dir_mapped,
    input wire logic        dir_valid,
    input wire logic [15:0] gr_addr,
    input wire logic        irq_accept
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire logic [15:0] stat = regs.program_status;
    wire logic [15:0] acc  = regs.accumulator;
    wire logic [15:0] tmp  = regs.temporary_accumulator;

    pc_step_a: assert property (pc_inc && !wb_ack
        && !(core_wr.en && core_wr.sel == SEL_PROGRAM_COUNTER)
        |=> regs.program_counter == $past(regs.program_counter) + 16'h0001)
        else $error("program counter did not step by one");
    byte_add_a: assert property (alu_req.go && !alu_req.sub && !alu_req.wide
        |=> acc == {$past(acc[15:8]), $past(acc[7:0]) + $past(tmp[7:0])})
        else $error("byte add result wrong");
    half_carry_a: assert property (alu_req.go && !alu_req.sub && !alu_req.wide
        |=> stat[7] == (({1'h0, $past(acc[3:0])} + $past(tmp[3:0])) > 5'h0F))
        else $error("half carry wrong");
    byte_flags_a: assert property (alu_req.go && !alu_req.wide
        |=> stat[3] == acc[7] && stat[2] == (acc[7:0] == 8'h00))
        else $error("negative or zero flag wrong");
    shift_carry_a: assert property (alu_req.shift && !alu_req.go
        |=> stat[0] == ($past(alu_req.left) ? $past(acc[7]) : $past(acc[0])))
        else $error("shift carry wrong");
    window_map_a: assert property (dir_go && dir_addr[7]
        |=> dir_valid && dir_mapped == DIRECT_WINDOW_BASE
            + 16'h0080 * $past(stat[10:8]) + $past(dir_addr[6:0]))
        else $error("direct window address wrong");
    low_direct_a: assert property (dir_go && !dir_addr[7]
        |=> dir_valid && dir_mapped == {8'h00, $past(dir_addr)})
        else $error("low direct address altered");
    irq_gate_a: assert property (!$past(sys_rst) |-> irq_accept ==
        ($past(irq_req) && $past(stat[6]) && $past(irq_level) < $past(stat[5:4])))
        else $error("interrupt acceptance wrong");
    bank_addr_a: assert property (!$past(sys_rst) |-> gr_addr == GR_BASE
        + 16'h0008 * $past(stat[15:11]) + $past(opcode[2:0]))
        else $error("general register address wrong");
endmodule

bind cpu_status_and_register_banks core_asserts #(.GR_BASE(GR_BASE)) chk_i (
    .ref_clk, .sys_rst, .wb_ack, .core_wr, .pc_inc, .alu_req, .dir_go, .dir_addr,
    .opcode, .irq_req, .irq_level, .regs, .dir_mapped, .dir_valid, .gr_addr, .irq_accept
);

// file: verif/decoder_model.sv
`timescale 1ns/10ps
module decoder_model
    import cpu_core_pkg::*;
(
    input  wire logic       ref_clk,
    output reg_write_t      core_wr,
    output logic            pc_inc,
    output alu_req_t        alu_req,
    output logic            dir_go,
    output logic [7:0]      dir_addr,
    output logic [7:0]      opcode,
    output logic            gr_we,
    output logic [7:0]      gr_wdata,
    output logic            irq_req,
    output logic [1:0]      irq_level
);
    initial begin
        core_wr = '0;
        {pc_inc, alu_req, dir_go, dir_addr, opcode} = '0;
        {gr_we, gr_wdata, irq_req, irq_level} = '0;
    end
    task automatic put(input reg_sel_t s, input logic [15:0] d);
        @(posedge ref_clk);
        core_wr <= '{1'h1, s, d};
        @(posedge ref_clk);
        core_wr <= '{1'h0, s, ~d};
    endtask
    task automatic alu(input alu_req_t q);
        @(posedge ref_clk);
        alu_req <= q;
        @(posedge ref_clk);
        alu_req <= '0;
    endtask
    task automatic step();
        @(posedge ref_clk);
        pc_inc <= 1'h1;
        @(posedge ref_clk);
        pc_inc <= 1'h0;
    endtask
    // Released lines flip so a stale value cannot pass for a fresh one
    task automatic dir(input logic [7:0] a);
        @(posedge ref_clk);
        dir_go <= 1'h1;
        dir_addr <= a;
        @(posedge ref_clk);
        dir_go <= 1'h0;
        dir_addr <= ~a;
    endtask
    task automatic grw(input logic we, input logic [7:0] op, input logic [7:0] d);
        @(posedge ref_clk);
        opcode <= op;
        gr_we <= we;
        gr_wdata <= d;
        @(posedge ref_clk);
        gr_we <= 1'h0;
        gr_wdata <= ~d;
    endtask
    task automatic irq(input logic r, input logic [1:0] l);
        @(posedge ref_clk);
        irq_req <= r;
        irq_level <= l;
    endtask
endmodule

// file: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    import cpu_core_pkg::*;
    logic        ref_clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0]  wb_adr, dir_addr, opcode, gr_wdata, gr_rdata;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, rd;
    logic [15:0] dir_mapped, gr_addr;
    logic [1:0]  irq_level;
    logic        pc_inc, dir_go, dir_valid, gr_we, irq_req, irq_accept;
    reg_write_t  core_wr;
    alu_req_t    alu_req;
    core_regs_t  regs;
    int          num_errors = 0;
    int          n_tests = 0;

    cpu_status_and_register_banks dut (.*);
    decoder_model m (.ref_clk, .core_wr, .pc_inc, .alu_req, .dir_go, .dir_addr,
        .opcode, .gr_we, .gr_wdata, .irq_req, .irq_level);

    initial begin
        ref_clk = 1'h0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        @(posedge ref_clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} <= {2'h3, we, a, s, d};
        do @(posedge ref_clk); while (wb_ack !== 1'h1);
        rd = wb_dat_r;
        {wb_cyc, wb_stb} <= 2'h0;
    endtask
    task automatic alu_case(input logic [15:0] a, t, p0, input alu_req_t q,
                            input logic [15:0] ea, ep);
        m.put(SEL_PROGRAM_STATUS, p0);
        m.put(SEL_ACCUMULATOR, a);
        m.put(SEL_TEMPORARY_ACC, t);
        m.alu(q);
        #1;
        chk(regs.accumulator, ea);
        chk(regs.program_status, ep);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = '0;
        sys_rst = 1'h1;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'h0;
        for (int i = 0; i < 7; i++) begin
            wb(1'h0, 8'(i * 4), 4'hF, 32'h0);
            chk(rd, 32'h0);
        end
        for (int i = 0; i < 7; i++) begin
            wb(1'h1, 8'(i * 4), 4'hF, 32'hABCD_1357 + 32'h1111 * i);
            wb(1'h0, 8'(i * 4), 4'hF, 32'h0);
            chk(rd, 32'h1357 + 32'h1111 * i);
        end
        wb(1'h1, OFF_ACCUMULATOR, 4'h2, 32'hFFFF_FFFF);
        wb(1'h0, OFF_ACCUMULATOR, 4'hF, 32'h0);
        chk(rd, 32'hFF68);
        wb(1'h1, 8'h1C, 4'hF, 32'h1234);
        wb(1'h0, 8'h1C, 4'hF, 32'h0);
        chk(rd, 32'h0);
        $display("register bus test done");
        alu_case(16'h12F8, 16'h0008, 16'h0000, 5'h10, 16'h1200, 16'h0085);
        alu_case(16'h007F, 16'h0001, 16'h0040, 5'h10, 16'h0080, 16'h00CA);
        alu_case(16'h0000, 16'h0001, 16'h0000, 5'h18, 16'h00FF, 16'h0089);
        alu_case(16'h0010, 16'h0001, 16'h0000, 5'h18, 16'h000F, 16'h0080);
        alu_case(16'h8000, 16'h8000, 16'h0000, 5'h14, 16'h0000, 16'h0007);
        alu_case(16'h5581, 16'h0000, 16'h0082, 5'h03, 16'h5502, 16'h0083);
        alu_case(16'h0001, 16'h0000, 16'h0000, 5'h02, 16'h0000, 16'h0005);
        $display("arithmetic flag test done");
        for (int i = 0; i < 8; i++) begin
            m.put(SEL_PROGRAM_STATUS, 16'(i) << 8);
            m.dir(8'h85);
            #1;
            chk(dir_mapped, 16'h0085 + 16'h0080 * 16'(i));
            chk(dir_valid, 32'h1);
            m.dir(8'h7F);
            #1;
            chk(dir_mapped, 16'h007F);
        end
        $display("direct mapping test done");
        // Second pass rereads, so two banks sharing storage would show up
        for (int p = 0; p < 2; p++) begin
            for (int b = 0; b < 32; b += 31) begin
                for (int r = 0; r < 8; r += 7) begin
                    m.put(SEL_PROGRAM_STATUS, 16'(b) << 11);
                    m.grw(p == 0, 8'hF8 | 8'(r), 8'hA0 + 8'(b + r));
                    @(posedge ref_clk);
                    #1;
                    chk(gr_addr, GR_BASE_DEFAULT + 16'(b * 8 + r));
                    chk(gr_rdata, 8'hA0 + 8'(b + r));
                end
            end
        end
        $display("register bank test done");
        m.put(SEL_PROGRAM_STATUS, 16'h0030);
        m.irq(1'h1, 2'h0);
        @(posedge ref_clk);
        #1;
        chk(irq_accept, 32'h0);
        for (int il = 0; il < 4; il += 2) begin
            for (int l = 0; l < 4; l++) begin
                m.put(SEL_PROGRAM_STATUS, 16'h0040 | 16'(il << 4));
                m.irq(1'h1, 2'(l));
                @(posedge ref_clk);
                #1;
                chk(irq_accept, 32'(l < il));
            end
        end
        m.irq(1'h0, 2'h0);
        $display("interrupt gate test done");
        m.put(SEL_PROGRAM_COUNTER, 16'hFFFF);
        m.step();
        #1;
        chk(regs.program_counter, 32'h0);
        $display("program counter test done");
        report_and_stop;
    end

    initial begin
        #100000;
        num_errors++;
        report_and_stop;
    end
endmodule
